// *** hw/link_status_pkg.sv ***
// Package with register map, field layout and reset values of the link status slice.
package link_status_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ALIAS_SEVEN_OFFSET     = 8'h48;
  localparam logic [7:0] BACK_CTRL_OFFSET       = 8'h49;
  localparam logic [7:0] REVISION_OFFSET        = 8'h50;
  localparam logic [7:0] INIT_STATUS_OFFSET     = 8'h51;
  localparam logic [7:0] GENERAL_STATUS_OFFSET  = 8'h52;
  localparam logic [7:0] PIN_STATUS_OFFSET      = 8'h53;
  localparam logic [7:0] SELFTEST_COUNT_OFFSET  = 8'h54;
  localparam logic [7:0] FAULT_COUNT_LO_OFFSET  = 8'h55;
  localparam logic [7:0] FAULT_COUNT_HI_OFFSET  = 8'h56;
  localparam logic [7:0] REMOTE_ID_SEVEN_OFFSET = 8'h78;

  // ==========================================================================
  // Field positions
  localparam int ALIAS_ADDR_LSB      = 1;
  localparam int ALIAS_AUTO_ACK_BIT  = 0;
  localparam int CTRL_SELFTEST_CLR   = 5;
  localparam int CTRL_SPARE_BIT      = 4;
  localparam int CTRL_FAULT_CLR      = 3;
  localparam int CTRL_TIMER_MSB      = 2;
  localparam int INIT_CKSUM_OK_BIT   = 7;
  localparam int INIT_DONE_BIT       = 6;
  localparam int GEN_REMOTE_LOCK_BIT = 6;
  localparam int GEN_LINK_LOST_BIT   = 4;
  localparam int GEN_SELFTEST_BIT    = 3;
  localparam int GEN_PLL_LOCK_BIT    = 2;
  localparam int GEN_FAULT_BIT       = 1;
  localparam int GEN_LINK_VALID_BIT  = 0;
  localparam int PIN_COUNT           = 4;
  localparam int FAULT_COUNT_WIDTH   = 16;
  localparam int SELFTEST_WIDTH      = 8;

  // ==========================================================================
  // Reset values
  localparam logic [6:0] ALIAS_RESET      = 7'h00;
  localparam logic [6:0] REMOTE_ID_RESET  = 7'h00;
  localparam logic [2:0] TIMER_RESET      = 3'h0;
  localparam logic       PLL_LOCK_RESET   = 1'b1;
  localparam logic       LINK_VALID_RESET = 1'b1;
  localparam logic [3:0] PIN_RESET        = 4'h0;
  localparam logic [7:0] READ_IDLE        = 8'h00;

endpackage : link_status_pkg

// *** hw/sat_counter.sv ***
// Saturating event counter whose clear, with a coincident event, restarts the count at one.
`timescale 1ns/1ns
module sat_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             count_event,
  input  wire logic             clear,
  // Count
  output logic      [WIDTH-1:0] count_r
);

  logic [WIDTH-1:0] count_nxt;

  // ==========================================================================
  // Next count
  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = '0;
    end
    if (count_event && (clear || count_r != {WIDTH{1'b1}})) begin
      count_nxt = (clear ? {WIDTH{1'b0}} : count_r) + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : sat_counter

// *** hw/alias_decoder.sv ***
// Remote target alias decoder with address substitution and debug auto-acknowledge.
`timescale 1ns/1ns
module alias_decoder (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Configuration
  input  wire logic [6:0] alias_addr,
  input  wire logic [6:0] remote_id,
  input  wire logic       auto_ack_en,
  // Incoming transaction
  input  wire logic       req_valid,
  input  wire logic [6:0] req_addr,
  input  wire logic       req_write,
  // Forwarded transaction
  output logic            fwd_valid_r,
  output logic      [6:0] fwd_addr_r,
  output logic            auto_ack_r
);

  logic hit;

  // ==========================================================================
  // Match
  assign hit = req_valid && (alias_addr != 7'h00) && (req_addr == alias_addr);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid_r <= 1'b0;
      fwd_addr_r  <= 7'h00;
      auto_ack_r  <= 1'b0;
    end else begin
      fwd_valid_r <= hit;
      fwd_addr_r  <= hit ? remote_id : 7'h00;
      auto_ack_r  <= hit && req_write && auto_ack_en;
    end
  end

endmodule : alias_decoder

// *** hw/serializer_link_status_regs.sv ***
// Control and status register slice of the serializer back channel.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module serializer_link_status_regs
  import link_status_pkg::*;
#(
  // Arbitrary identification values.
  parameter logic [3:0] SILICON_REV  = 4'h1,
  parameter logic [3:0] LAYOUT_VER   = 4'h0
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // I2C transaction from the local controller
  input  wire logic       i2c_req_valid,
  input  wire logic [6:0] i2c_req_addr,
  input  wire logic       i2c_req_write,
  // Forwarded I2C transaction
  output logic            i2c_fwd_valid,
  output logic      [6:0] i2c_fwd_addr,
  output logic            i2c_auto_ack,
  // Power-up configuration
  input  wire logic       fuse_load_done,
  input  wire logic       fuse_checksum_valid,
  // Link state from the back-channel logic
  input  wire logic       back_link_valid,
  input  wire logic       forward_pll_locked,
  input  wire logic       remote_lock,
  input  wire logic       checksum_error,
  input  wire logic       selftest_mode,
  input  wire logic       selftest_error,
  // General-purpose pins
  input  wire logic [3:0] pin_levels,
  input  wire logic [3:0] pin_is_input,
  // Control outputs
  output logic      [2:0] link_detection_timer,
  output logic            checksum_fault_clear,
  output logic            selftest_count_clear
);

  // ==========================================================================
  // Declarations
  logic [6:0]  remote_alias_addr_seven_r;
  logic        auto_ack_en_r;
  logic [6:0]  remote_id_seven_r;
  logic [2:0]  timer_r;
  logic        ctrl_spare_r;
  logic        fault_clr_r;
  logic        selftest_clr_r;
  logic        fuse_checksum_ok_r;
  logic        init_done_r;
  logic        remote_lock_r;
  logic        link_lost_r;
  logic        selftest_fault_flag_r;
  logic        forward_pll_locked_r;
  logic        fault_flag_r;
  logic        back_link_valid_r;
  logic [3:0]  pin_meta_r;
  logic [3:0]  pin_sync_r;
  logic [3:0]  pin_input_levels_r;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        fault_clear_req;
  logic        selftest_clear_req;
  logic        link_change;
  logic        pll_unlock;
  logic        fault_event;
  logic        selftest_event;
  logic [7:0]  selftest_fault_count;
  logic [15:0] fault_count;

  // ==========================================================================
  // Decode
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] offset);
    hit = strobe && (addr == offset);
  endfunction : hit

  assign fault_clear_req    = (hit(reg_wr, reg_addr, BACK_CTRL_OFFSET)
                               && reg_wdata[CTRL_FAULT_CLR])
                              || hit(reg_rd, reg_addr, BACK_CTRL_OFFSET);
  assign selftest_clear_req = hit(reg_wr, reg_addr, BACK_CTRL_OFFSET)
                              && reg_wdata[CTRL_SELFTEST_CLR];
  assign link_change        = back_link_valid != back_link_valid_r;
  assign pll_unlock         = forward_pll_locked_r && !forward_pll_locked;
  assign fault_event        = checksum_error && back_link_valid;
  assign selftest_event     = selftest_error && selftest_mode;

  // ==========================================================================
  // Alias seven and remote target id
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_alias_addr_seven_r <= ALIAS_RESET;
      auto_ack_en_r             <= 1'b0;
    end else if (hit(reg_wr, reg_addr, ALIAS_SEVEN_OFFSET)) begin
      remote_alias_addr_seven_r <= reg_wdata[7:ALIAS_ADDR_LSB];
      auto_ack_en_r             <= reg_wdata[ALIAS_AUTO_ACK_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_id_seven_r <= REMOTE_ID_RESET;
    end else if (hit(reg_wr, reg_addr, REMOTE_ID_SEVEN_OFFSET)) begin
      remote_id_seven_r <= reg_wdata[7:ALIAS_ADDR_LSB];
    end
  end

  alias_decoder u_alias_decoder (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .alias_addr  (remote_alias_addr_seven_r),
    .remote_id   (remote_id_seven_r),
    .auto_ack_en (auto_ack_en_r),
    .req_valid   (i2c_req_valid),
    .req_addr    (i2c_req_addr),
    .req_write   (i2c_req_write),
    .fwd_valid_r (i2c_fwd_valid),
    .fwd_addr_r  (i2c_fwd_addr),
    .auto_ack_r  (i2c_auto_ack)
  );

  // ==========================================================================
  // Back-channel control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r      <= TIMER_RESET;
      ctrl_spare_r <= 1'b0;
    end else if (hit(reg_wr, reg_addr, BACK_CTRL_OFFSET)) begin
      timer_r      <= reg_wdata[CTRL_TIMER_MSB:0];
      ctrl_spare_r <= reg_wdata[CTRL_SPARE_BIT];
    end
  end

  // ==========================================================================
  // Self-clearing clear strobes, high for one cycle after the access.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_clr_r <= 1'b0;
    end else begin
      fault_clr_r <= fault_clear_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      selftest_clr_r <= 1'b0;
    end else begin
      selftest_clr_r <= selftest_clear_req;
    end
  end

  // ==========================================================================
  // Power-up configuration status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_r <= 1'b0;
    end else if (fuse_load_done) begin
      init_done_r <= 1'b1;
    end
  end

  // The checksum result is taken once, on the first cycle of a finished load.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_checksum_ok_r <= 1'b0;
    end else if (fuse_load_done && !init_done_r) begin
      fuse_checksum_ok_r <= fuse_checksum_valid;
    end
  end

  // ==========================================================================
  // Link state sampling
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_lock_r <= 1'b0;
    end else begin
      remote_lock_r <= remote_lock;
    end
  end

  // The delayed copy also serves the unlock edge detector, so it resets locked.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      forward_pll_locked_r <= PLL_LOCK_RESET;
    end else begin
      forward_pll_locked_r <= forward_pll_locked;
    end
  end

  // The delayed copy also serves the link change detector, so it resets valid.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      back_link_valid_r <= LINK_VALID_RESET;
    end else begin
      back_link_valid_r <= back_link_valid;
    end
  end

  // ==========================================================================
  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_lost_r <= 1'b0;
    end else if (link_change) begin
      link_lost_r <= 1'b1;
    end else if (fault_clear_req || pll_unlock) begin
      link_lost_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_flag_r <= 1'b0;
    end else if (fault_event) begin
      fault_flag_r <= 1'b1;
    end else if (fault_clear_req) begin
      fault_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      selftest_fault_flag_r <= 1'b0;
    end else if (selftest_event) begin
      selftest_fault_flag_r <= 1'b1;
    end else if (selftest_clear_req) begin
      selftest_fault_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Error counters
  sat_counter #(
    .WIDTH (SELFTEST_WIDTH)
  ) u_selftest_count (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .count_event (selftest_event),
    .clear       (selftest_clear_req),
    .count_r     (selftest_fault_count)
  );

  sat_counter #(
    .WIDTH (FAULT_COUNT_WIDTH)
  ) u_fault_count (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .count_event (fault_event),
    .clear       (fault_clear_req),
    .count_r     (fault_count)
  );

  // ==========================================================================
  // General-purpose pin readback
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= PIN_RESET;
      pin_sync_r <= PIN_RESET;
    end else begin
      pin_meta_r <= pin_levels;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_input_levels_r <= PIN_RESET;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (pin_is_input[i]) begin
          pin_input_levels_r[i] <= pin_sync_r[i];
        end
      end
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    rdata_nxt = READ_IDLE;
    if (reg_rd) begin
      case (reg_addr)
        ALIAS_SEVEN_OFFSET: begin
          rdata_nxt = {remote_alias_addr_seven_r, auto_ack_en_r};
        end
        BACK_CTRL_OFFSET: begin
          rdata_nxt = {3'h0, ctrl_spare_r, 1'b0, timer_r};
        end
        REVISION_OFFSET: begin
          rdata_nxt = {SILICON_REV, LAYOUT_VER};
        end
        INIT_STATUS_OFFSET: begin
          rdata_nxt[INIT_CKSUM_OK_BIT] = fuse_checksum_ok_r;
          rdata_nxt[INIT_DONE_BIT]     = init_done_r;
        end
        GENERAL_STATUS_OFFSET: begin
          rdata_nxt[GEN_REMOTE_LOCK_BIT] = remote_lock_r;
          rdata_nxt[GEN_LINK_LOST_BIT]   = link_lost_r;
          rdata_nxt[GEN_SELFTEST_BIT]    = selftest_fault_flag_r;
          rdata_nxt[GEN_PLL_LOCK_BIT]    = forward_pll_locked_r;
          rdata_nxt[GEN_FAULT_BIT]       = fault_flag_r;
          rdata_nxt[GEN_LINK_VALID_BIT]  = back_link_valid_r;
        end
        PIN_STATUS_OFFSET: begin
          rdata_nxt = {4'h0, pin_input_levels_r};
        end
        SELFTEST_COUNT_OFFSET: begin
          rdata_nxt = selftest_fault_count;
        end
        FAULT_COUNT_LO_OFFSET: begin
          rdata_nxt = fault_count[7:0];
        end
        FAULT_COUNT_HI_OFFSET: begin
          rdata_nxt = fault_count[15:8];
        end
        REMOTE_ID_SEVEN_OFFSET: begin
          rdata_nxt = {remote_id_seven_r, 1'b0};
        end
        default: begin
          rdata_nxt = READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= READ_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata            = rdata_r;
  assign link_detection_timer = timer_r;
  assign checksum_fault_clear = fault_clr_r;
  assign selftest_count_clear = selftest_clr_r;

endmodule : serializer_link_status_regs

// *** dv/link_status_checker.sv ***
// Concurrent checks on the ports of the link status register slice.
`timescale 1ns/1ns
module link_status_checker (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // I2C decode
  input wire logic       i2c_req_valid,
  input wire logic [6:0] i2c_req_addr,
  input wire logic       i2c_req_write,
  input wire logic       i2c_fwd_valid,
  input wire logic       i2c_auto_ack,
  // Control outputs
  input wire logic [2:0] link_detection_timer,
  input wire logic       checksum_fault_clear,
  input wire logic       selftest_count_clear
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [6:0] alias_r;
  logic       ctl_wr;
  // ==========================================================================
  // Helper logic
  // Shadow of the alias field, kept from writes on the register port.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alias_r <= 7'h00;
    end else if (reg_wr && reg_addr == 8'h48) begin
      alias_r <= reg_wdata[7:1];
    end
  end
  assign ctl_wr = reg_wr && reg_addr == 8'h49;
  // ==========================================================================
  // Assertions
  a_alias_hit: assert property (i2c_req_valid && alias_r != 7'h00 && i2c_req_addr == alias_r
    |=> i2c_fwd_valid) else $error("alias match not forwarded");
  a_alias_off: assert property (i2c_req_valid && alias_r == 7'h00 |=> !i2c_fwd_valid)
    else $error("forward with alias zero");
  a_fwd_cause: assert property (i2c_fwd_valid |-> $past(i2c_req_valid))
    else $error("forward without request");
  a_ack_write: assert property (i2c_auto_ack |-> i2c_fwd_valid && $past(i2c_req_write))
    else $error("auto ack without matched write");
  a_fault_clr: assert property (ctl_wr && reg_wdata[3] |=> checksum_fault_clear)
    else $error("checksum clear pulse missing");
  a_st_clr: assert property (ctl_wr && reg_wdata[5] |=> selftest_count_clear)
    else $error("self-test clear pulse missing");
  a_st_self: assert property (ctl_wr && reg_wdata[5] ##1 !(ctl_wr && reg_wdata[5])
    |=> !selftest_count_clear) else $error("self-test clear stuck");
  a_timer_wr: assert property (ctl_wr |=> link_detection_timer == $past(reg_wdata[2:0]))
    else $error("timer field not written");
  a_alias_read: assert property (reg_rd && reg_addr == 8'h48
    |=> reg_rdata[7:1] == alias_r) else $error("alias field readback wrong");
  // ==========================================================================
  // Cover points
  c_fwd: cover property (i2c_fwd_valid && i2c_auto_ack);
  c_clr: cover property (checksum_fault_clear);
  c_st: cover property (selftest_count_clear);
endmodule : link_status_checker

bind serializer_link_status_regs link_status_checker u_chk (.sys_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .i2c_req_valid, .i2c_req_addr, .i2c_req_write,
  .i2c_fwd_valid, .i2c_auto_ack, .link_detection_timer, .checksum_fault_clear,
  .selftest_count_clear);

// *** dv/remote_deser_model.sv ***
// Behavioural model of the remote deserializer seen through the back channel.
`timescale 1ns/1ns
module remote_deser_model (
  // Clock
  input wire logic sys_clk,
  // Back-channel state
  output logic     back_link_valid,
  output logic     remote_lock,
  output logic     checksum_error
);
  initial begin
    back_link_valid = 1'b1;
    remote_lock     = 1'b0;
    checksum_error  = 1'b0;
  end
  // ==========================================================================
  // Link state changes, one edge each.
  task automatic set_link(input logic v);
    @(posedge sys_clk);
    back_link_valid <= v;
  endtask : set_link
  task automatic set_lock(input logic v);
    @(posedge sys_clk);
    remote_lock <= v;
  endtask : set_lock
  // Checksum error pulses, one cycle each with a gap between them.
  task automatic send_errors(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      checksum_error <= 1'b1;
      @(posedge sys_clk);
      checksum_error <= 1'b0;
    end
  endtask : send_errors
endmodule : remote_deser_model

// *** dv/test_serializer_link_status_regs.sv ***
// Self-checking testbench of the link status register slice.
`timescale 1ns/1ns
module test_serializer_link_status_regs;
  import link_status_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic i2c_req_valid = 1'b0, i2c_req_write = 1'b0;
  logic [6:0] i2c_req_addr = 7'h00, i2c_fwd_addr;
  logic i2c_fwd_valid, i2c_auto_ack, checksum_fault_clear, selftest_count_clear;
  logic fuse_load_done = 1'b0, fuse_checksum_valid = 1'b0, forward_pll_locked = 1'b1;
  logic selftest_mode = 1'b0, selftest_error = 1'b0;
  logic back_link_valid, remote_lock, checksum_error;
  logic [3:0] pin_levels = 4'h0, pin_is_input = 4'h0;
  logic [2:0] link_detection_timer;
  int n_errors = 0, comparisons = 0;
  always #25 sys_clk = ~sys_clk;
  serializer_link_status_regs u_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .i2c_req_valid, .i2c_req_addr, .i2c_req_write, .i2c_fwd_valid,
    .i2c_fwd_addr, .i2c_auto_ack, .fuse_load_done, .fuse_checksum_valid, .back_link_valid,
    .forward_pll_locked, .remote_lock, .checksum_error, .selftest_mode, .selftest_error,
    .pin_levels, .pin_is_input, .link_detection_timer, .checksum_fault_clear,
    .selftest_count_clear);
  remote_deser_model u_far (.sys_clk, .back_link_valid, .remote_lock, .checksum_error);
  // ==========================================================================
  // Bus and request tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic req(input logic [6:0] a, input logic w, input logic [8:0] e);
    @(posedge sys_clk);
    i2c_req_valid <= 1'b1; i2c_req_addr <= a; i2c_req_write <= w;
    @(posedge sys_clk);
    i2c_req_valid <= 1'b0;
    #1 `CHK({i2c_fwd_valid, i2c_fwd_addr, i2c_auto_ack}, e)
  endtask : req
  task automatic settle();
    repeat (5) @(posedge sys_clk);
  endtask : settle
  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    rd(8'h48, 8'h00);
    rd(8'h49, 8'h00);
    rd(8'h50, 8'h10);
    rd(8'h51, 8'h00);
    rd(8'h52, 8'h05);
    rd(8'h53, 8'h00);
    rd(8'h54, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h00);
    rd(8'h60, 8'h00);
  endtask : t_reset_values
  task automatic t_alias();
    wr(8'h78, 8'h42);
    req(7'h00, 1'b1, 9'h000);
    wr(8'h48, 8'h75);
    rd(8'h48, 8'h75);
    req(7'h3a, 1'b1, {1'b1, 7'h21, 1'b1});
    req(7'h3a, 1'b0, {1'b1, 7'h21, 1'b0});
    req(7'h3b, 1'b1, 9'h000);
    wr(8'h48, 8'h74);
    req(7'h3a, 1'b1, {1'b1, 7'h21, 1'b0});
  endtask : t_alias
  task automatic t_fuse();
    @(posedge sys_clk);
    fuse_checksum_valid <= 1'b1;
    fuse_load_done <= 1'b1;
    settle();
    rd(8'h51, 8'hc0);
  endtask : t_fuse
  task automatic t_link();
    u_far.set_lock(1'b1);
    u_far.set_link(1'b0);
    settle();
    rd(8'h52, 8'h54);
    rd(8'h49, 8'h00);
    rd(8'h52, 8'h44);
    u_far.set_link(1'b1);
    settle();
    rd(8'h52, 8'h55);
    @(posedge sys_clk);
    forward_pll_locked <= 1'b0;
    settle();
    rd(8'h52, 8'h41);
    @(posedge sys_clk);
    forward_pll_locked <= 1'b1;
    u_far.send_errors(3);
    settle();
    rd(8'h52, 8'h47);
    rd(8'h52, 8'h47);
    rd(8'h55, 8'h03);
    rd(8'h56, 8'h00);
    wr(8'h49, 8'h1f);
    #1 `CHK(checksum_fault_clear, 1'b1)
    `CHK(link_detection_timer, 3'h7)
    settle();
    rd(8'h52, 8'h45);
    rd(8'h55, 8'h00);
    rd(8'h49, 8'h17);
  endtask : t_link
  task automatic t_selftest();
    @(posedge sys_clk);
    selftest_mode <= 1'b1;
    repeat (260) begin
      @(posedge sys_clk);
      selftest_error <= 1'b1;
      @(posedge sys_clk);
      selftest_error <= 1'b0;
    end
    settle();
    rd(8'h54, 8'hff);
    rd(8'h52, 8'h4d);
    wr(8'h49, 8'h20);
    #1 `CHK(selftest_count_clear, 1'b1)
    settle();
    rd(8'h54, 8'h00);
    rd(8'h52, 8'h45);
    @(posedge sys_clk);
    selftest_mode <= 1'b0;
    @(posedge sys_clk);
    selftest_error <= 1'b1;
    @(posedge sys_clk);
    selftest_error <= 1'b0;
    settle();
    rd(8'h54, 8'h00);
  endtask : t_selftest
  task automatic t_pins();
    @(posedge sys_clk);
    pin_is_input <= 4'h5;
    pin_levels <= 4'hf;
    settle();
    rd(8'h53, 8'h05);
    @(posedge sys_clk);
    pin_levels <= 4'ha;
    pin_is_input <= 4'hf;
    settle();
    rd(8'h53, 8'h0a);
    @(posedge sys_clk);
    pin_is_input <= 4'h0;
    pin_levels <= 4'h5;
    settle();
    rd(8'h53, 8'h0a);
  endtask : t_pins
  // ==========================================================================
  // Verdict and run control
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_alias();
    t_fuse();
    t_link();
    t_selftest();
    t_pins();
    tally_and_finish();
  end
endmodule : test_serializer_link_status_regs
